/* bench/pls_sel_assertions.sv */
module pls_sel_checker #(
  parameter ADDR_WIDTH = 12
) (
  input logic                  clock,
  input logic                  sys_rst,
  input logic [ADDR_WIDTH-1:0] awaddr,
  input logic                  awvalid,
  input logic                  awready,
  input logic [31:0]           wdata,
  input logic [3:0]            wstrb,
  input logic                  wvalid,
  input logic                  wready,
  input logic [1:0]            bresp,
  input logic                  bvalid,
  input logic                  bready,
  input logic [31:0]           rdata,
  input logic                  rvalid,
  input logic                  rready,
  input logic [4:0]            sysRefCount,
  input logic [7:0]            sysFeedbackDivider,
  input logic [1:0]            sysRangeSelectCode,
  input logic                  sysPreDivideTwo,
  input logic [7:0]            sysTotalRefDivide,
  input logic [4:0]            pixRefCount,
  input logic [7:0]            pixFeedbackDivider,
  input logic [1:0]            pixRangeSelectCode,
  input logic                  pixPreDivideTwo,
  input logic [7:0]            pixTotalRefDivide
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  // Outputs still hold reset levels on the first edge after release
  sequence s_wrTaken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_fbWr;
    s_wrTaken ##0 (wstrb[0] && awaddr == 'h58);
  endsequence

  property p_sysPre;
    !$fell(sys_rst) |-> sysPreDivideTwo == (sysRangeSelectCode != 2'h3);
  endproperty
  a_sysPre: assert property (p_sysPre) else $error("sys pre-divide wrong");
  property p_sysTotal;
    !$fell(sys_rst) |-> sysTotalRefDivide == ({3'h0, sysRefCount} << (2'h3 - sysRangeSelectCode));
  endproperty
  a_sysTotal: assert property (p_sysTotal) else $error("sys total divide wrong");
  property p_pixDiv;
    !$fell(sys_rst) |-> pixPreDivideTwo == (pixRangeSelectCode != 2'h3) &&
      pixTotalRefDivide == ({3'h0, pixRefCount} << (2'h3 - pixRangeSelectCode));
  endproperty
  a_pixDiv: assert property (p_pixDiv) else $error("pix divide wrong");
  property p_fbSpan;
    !$fell(sys_rst) |-> sysFeedbackDivider inside {[8'd65:8'd128]} &&
      pixFeedbackDivider inside {[8'd65:8'd128]};
  endproperty
  a_fbSpan: assert property (p_fbSpan) else $error("feedback divider out of span");
  property p_rstLoad;
    $fell(sys_rst) |=> sysFeedbackDivider == 8'd66 && sysTotalRefDivide == 8'd32 &&
      pixFeedbackDivider == 8'd70 && pixTotalRefDivide == 8'd40;
  endproperty
  a_rstLoad: assert property (p_rstLoad) else $error("power-on values wrong");
  property p_sysWrite;
    s_fbWr |-> ##3 sysFeedbackDivider == 8'd65 + $past(wdata[5:0], 3) &&
      sysRangeSelectCode == $past(wdata[7:6], 3);
  endproperty
  a_sysWrite: assert property (p_sysWrite) else $error("sys feedback not applied");
  property p_bHold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_bHold: assert property (p_bHold) else $error("write response dropped");
  property p_rHold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_rHold: assert property (p_rHold) else $error("read data dropped");
endmodule // pls_sel_checker

bind pls_pll_select pls_sel_checker #(.ADDR_WIDTH(ADDR_WIDTH)) chk_u (.*);

/* bench/pls_tb.sv */
`include "pls_defines.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, sysPreDivideTwo, pixPreDivideTwo;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [2:0]  awprot, arprot, sysPostDivide, pixPostDivide;
  logic [1:0]  bresp, rresp, externalFreqSelectPins, sysRangeSelectCode, pixRangeSelectCode;
  logic [1:0]  r, pin;
  logic [4:0]  sysRefCount, pixRefCount, rf;
  logic [7:0]  sysFeedbackDivider, sysTotalRefDivide, pixFeedbackDivider, pixTotalRefDivide;
  logic [7:0]  slot [16];
  logic [7:0]  fixRef, fb;
  logic [26:0] e;
  logic [7:0]  rIdx [8] = '{8'h10, 8'h11, 8'h14, 8'h15, 8'h16, 8'h20, 8'h21, 8'h22};
  logic [7:0]  rVal [8] = '{8'h00, 8'h00, 8'h05, 8'h08, 8'h41, 8'h05, 8'h0E, 8'h00};
  int          err_total, n_tests;
  wire  [26:0] sysOut = {sysRefCount, sysFeedbackDivider, sysRangeSelectCode,
                         sysPreDivideTwo, sysPostDivide, sysTotalRefDivide};
  wire  [26:0] pixOut = {pixRefCount, pixFeedbackDivider, pixRangeSelectCode,
                         pixPreDivideTwo, pixPostDivide, pixTotalRefDivide};

  pls_pll_select dut_u (.*);

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // Stall delays the response handshake so the slave must hold its answer
  task automatic wr(input logic [7:0] idx, input logic [7:0] v, output logic [1:0] rsp,
                    input int st = 0);
    int k;
    k = 0;
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clock);
      k++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid || wvalid) && k < 99);
    repeat (st) @(posedge clock);
    bready <= 1'b1;
    do begin @(posedge clock); k++; end while (!bvalid && k < 99);
    rsp = bresp;
    bready <= 1'b0;
    if (k >= 99) err_total++;
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] v, output logic [1:0] rsp,
                    input int st = 0);
    int k;
    k = 0;
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    do begin @(posedge clock); k++; end while (!arready && k < 99);
    arvalid <= 1'b0;
    repeat (st) @(posedge clock);
    rready <= 1'b1;
    do begin @(posedge clock); k++; end while (!rvalid && k < 99);
    v = rdata;
    rsp = rresp;
    rready <= 1'b0;
    if (k >= 99) err_total++;
  endtask

  // Pre-divide by two times postscaler gives 8, 4, 2, 1
  function automatic logic [26:0] pll(logic [4:0] rc, logic [7:0] f);
    logic [1:0] c;
    c = f[7:6];
    return {rc, 8'd65 + {2'h0, f[5:0]}, c, c != 2'h3, c == 2'h0 ? 3'h4 : c == 2'h1 ? 3'h2 : 3'h1,
            {3'h0, rc} << (2'h3 - c)};
  endfunction

  function automatic logic [26:0] pixExp(logic [2:0] st, logic [3:0] fs, logic [1:0] p);
    case (st)
      3'h1: return pll(slot[{p, 1'b1}][4:0], slot[{p, 1'b0}]);
      3'h2: return pll(fixRef[4:0], slot[fs]);
      3'h3: return pll(slot[{fs[2:0], 1'b1}][4:0], slot[{fs[2:0], 1'b0}]);
      default: return pll(fixRef[4:0], slot[p]);
    endcase
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    wrap_up();
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, awprot, arprot, wdata, externalFreqSelectPins} = 64'h0;
    wstrb = 4'hF;
    sys_rst = 1'b1;
    err_total = 0;
    n_tests = 0;
    d = $urandom(32'h9437D943);
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clock);
    chk("sysOut", sysOut, pll(5'h08, 8'h41));
    chk("pixOut", pixOut, pll(5'h05, 8'h05));
    for (int i = 0; i < 8; i++) begin
      rd(rIdx[i], d, r);
      chk("regReset", d, {24'h0, rVal[i]});
    end
    externalFreqSelectPins <= 2'h1;
    repeat (2) @(posedge clock);
    chk("pinEarly", pixOut, pll(5'h05, 8'h05));
    repeat (3) @(posedge clock);
    chk("pinLate", pixOut, pll(5'h05, 8'h0E));
    $display("end reset test");
    rd(8'h12, d, r, 2);
    chk("unmapResp", r, `PLS_RESP_SLVERR);
    chk("unmapData", d, 32'h0);
    wr(8'h12, 8'hA5, r, 2);
    chk("unmapWrResp", r, `PLS_RESP_SLVERR);
    wr(8'h15, 8'hFF, r);
    rd(8'h15, d, r);
    chk("refUnused", d, 32'h1F);
    $display("end bus test");
    for (int i = 0; i < 24; i++) begin
      rf = 5'($urandom_range(31, 2));
      fb = 8'($urandom);
      if (i < 4) begin
        rf = i[0] ? 5'd31 : 5'd2;
        fb = {i[1:0], 6'(i * 21)};
      end
      wr(8'h15, {3'h0, rf}, r);
      wr(8'h16, fb, r);
      repeat (2) @(posedge clock);
      chk("sysOut", sysOut, pll(rf, fb));
    end
    $display("end system test");
    fixRef = 8'($urandom_range(31, 2));
    wr(8'h14, fixRef, r);
    for (int i = 0; i < 16; i++) begin
      slot[i] = 8'($urandom);
      if (i % 2 == 1)
        slot[i][4:0] = 5'($urandom_range(31, 2));
      wr(8'h20 + 8'(i), slot[i], r);
    end
    for (int st = 0; st < 8; st++) begin
      wr(8'h10, 8'(st), r);
      for (int s = 0; s < 16; s++) begin
        pin = 2'($urandom);
        wr(8'h11, 8'(s), r);
        externalFreqSelectPins <= pin;
        repeat (5) @(posedge clock);
        e = pixExp(3'(st), 4'(s), pin);
        chk("pixOut", pixOut, e);
        rd(8'h8F, d, r);
        chk("rbRef", d, {27'h0, e[26:22]});
        rd(8'h8E, d, r);
        chk("rbFb", d, {24'h0, e[13:12], 6'(e[21:14] - 8'd65)});
      end
    end
    $display("end pixel test");
    wrap_up();
  end
endmodule // tb

/* rtl/pls_defines.vh */
// Behaviour
// - Feedback divider equals the 6-bit feedback count plus 65, spanning 65 to 128.
// - Two-bit range code sets the pre-divide-by-two and the output postscaler.
// - Output equals reference times (count+65) over reference count times 8, 4, 2, 1.
// - Each PLL uses a 5-bit reference byte and a feedback-plus-range byte.
// - System PLL uses exactly one reference register and one feedback register.
// - Pixel PLL has a fixed reference divider and sixteen slots, one pair selected.
// - Direct style: fixed reference divider plus one of sixteen feedback slots.
// - Multiply-over-divide style: slots form eight pairs, multiply first, fixed ignored.
// - Selection from external 2-bit pins or internal 4-bit field; bit 3 ignored in pairs.
// - Style field 000, 001, 010, 011 pick source and style as tabled.
// - External selection gives four choices; internal gives eight pairs or sixteen slots.
// - Reset selects the legacy mode and loads legacy power-on values.
// - Reset loads system feedback byte 0x41 and system reference byte 0x08.
// - Reset loads slot 0 with 0x05, slot 1 with 0x0E, fixed divider 0x05.
`ifndef PLS_DEFINES_VH
`define PLS_DEFINES_VH

// ------------------------------------------------------------
// Register indices, byte address is four times the index
// ------------------------------------------------------------
`define PLS_IDX_PIX_CTRL1    8'h10
`define PLS_IDX_PIX_CTRL2    8'h11
`define PLS_IDX_PIX_FIXED    8'h14
`define PLS_IDX_SYS_REF      8'h15
`define PLS_IDX_SYS_FB       8'h16
`define PLS_IDX_SLOT_BASE    8'h20
`define PLS_IDX_SLOT_LAST    8'h2F
`define PLS_IDX_RB_FB        8'h8E
`define PLS_IDX_RB_REF       8'h8F

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define PLS_RST_SYS_FB       8'h41
`define PLS_RST_SYS_REF      5'h08
`define PLS_RST_PIX_FIXED    5'h05
`define PLS_RST_SLOT0        8'h05
`define PLS_RST_SLOT1        8'h0E
`define PLS_RST_SLOT_OTHER   8'h00
`define PLS_RST_STYLE        3'h0
`define PLS_RST_INT_SEL      4'h0

// ------------------------------------------------------------
// Style and source codes, field constants
// ------------------------------------------------------------
`define PLS_STYLE_EXT_DIRECT 3'h0
`define PLS_STYLE_EXT_PAIR   3'h1
`define PLS_STYLE_INT_DIRECT 3'h2
`define PLS_STYLE_INT_PAIR   3'h3
`define PLS_FB_OFFSET        8'h41
`define PLS_RANGE_LOW        2'h0
`define PLS_RANGE_MIDLOW     2'h1
`define PLS_RANGE_MIDHIGH    2'h2
`define PLS_RANGE_HIGH       2'h3
`define PLS_RESP_OKAY        2'h0
`define PLS_RESP_SLVERR      2'h2

`endif

/* rtl/pls_pll_select.v */
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`include "pls_defines.vh"

module pls_pll_select #(
  parameter ADDR_WIDTH = 12
) (
  input  wire                  clock,
  input  wire                  sys_rst,
  // AXI4-Lite slave
  input  wire [ADDR_WIDTH-1:0] awaddr,
  input  wire [2:0]            awprot,
  input  wire                  awvalid,
  output reg                   awready,
  input  wire [31:0]           wdata,
  input  wire [3:0]            wstrb,
  input  wire                  wvalid,
  output reg                   wready,
  output reg  [1:0]            bresp,
  output reg                   bvalid,
  input  wire                  bready,
  input  wire [ADDR_WIDTH-1:0] araddr,
  input  wire [2:0]            arprot,
  input  wire                  arvalid,
  output reg                   arready,
  output reg  [31:0]           rdata,
  output reg  [1:0]            rresp,
  output reg                   rvalid,
  input  wire                  rready,
  // External frequency select pins
  input  wire [1:0]            externalFreqSelectPins,
  // System clock PLL programming
  output reg  [4:0]            sysRefCount,
  output reg  [7:0]            sysFeedbackDivider,
  output reg  [1:0]            sysRangeSelectCode,
  output reg                   sysPreDivideTwo,
  output reg  [2:0]            sysPostDivide,
  output reg  [7:0]            sysTotalRefDivide,
  // Pixel PLL programming
  output reg  [4:0]            pixRefCount,
  output reg  [7:0]            pixFeedbackDivider,
  output reg  [1:0]            pixRangeSelectCode,
  output reg                   pixPreDivideTwo,
  output reg  [2:0]            pixPostDivide,
  output reg  [7:0]            pixTotalRefDivide
);

// ------------------------------------------------------------
// Functions
// ------------------------------------------------------------
function [7:0] feedbackDivider;
  input [5:0] count;
  begin
    feedbackDivider = {2'b00, count} + `PLS_FB_OFFSET;
  end
endfunction

function preDivideTwo;
  input [1:0] code;
  begin
    preDivideTwo = (code != `PLS_RANGE_HIGH);
  end
endfunction

function [2:0] postDivide;
  input [1:0] code;
  begin
    // Split of the 8/4/2/1 factor into pre-divide and postscaler
    if (code == `PLS_RANGE_LOW) begin
      postDivide = 3'h4;
    end else if (code == `PLS_RANGE_MIDLOW) begin
      postDivide = 3'h2;
    end else begin
      postDivide = 3'h1;
    end
  end
endfunction

function [7:0] totalRefDivide;
  input [4:0] count;
  input [1:0] code;
  begin
    // Largest product 31 x 8 still fits a byte
    if (code == `PLS_RANGE_LOW) begin
      totalRefDivide = {count, 3'b000};
    end else if (code == `PLS_RANGE_MIDLOW) begin
      totalRefDivide = {1'b0, count, 2'b00};
    end else if (code == `PLS_RANGE_MIDHIGH) begin
      totalRefDivide = {2'b00, count, 1'b0};
    end else begin
      totalRefDivide = {3'b000, count};
    end
  end
endfunction

function [8:0] regIndex;
  input [ADDR_WIDTH-1:0] addr;
  begin
    // Bit 8 flags an address outside the decoded window
    if ((addr >> 10) != 0 || addr[1:0] != 2'b00) begin
      regIndex = 9'h100;
    end else begin
      regIndex = {1'b0, addr[9:2]};
    end
  end
endfunction

// ------------------------------------------------------------
// Register storage
// ------------------------------------------------------------
reg [4:0]            sysRefReg;
reg [7:0]            sysFbReg;
reg [4:0]            pixFixedRef;
reg [7:0]            pixelValueSlots [0:15];
reg [2:0]            styleSourceField;
reg [3:0]            internalFreqSelectField;

reg                  awHeld;
reg                  wHeld;
reg [ADDR_WIDTH-1:0] awAddrHeld;
reg [7:0]            wByteHeld;
reg                  wLaneHeld;
reg [1:0]            extSelMeta;
reg [1:0]            extSelSync;

reg [7:0]            next_selFb;
reg [4:0]            next_selRef;
reg [8:0]            wrIndex;
reg [8:0]            rdIndex;
reg [7:0]            rdValue;
reg                  rdHit;
integer              i;

// ------------------------------------------------------------
// External select synchroniser
// ------------------------------------------------------------
always @(posedge clock or posedge sys_rst) begin
  if (sys_rst) begin
    extSelMeta <= 2'b00;
    extSelSync <= 2'b00;
  end else begin
    extSelMeta <= externalFreqSelectPins;
    extSelSync <= extSelMeta;
  end
end

// ------------------------------------------------------------
// Pair selection
// ------------------------------------------------------------
always @* begin
  next_selFb  = pixelValueSlots[0];
  next_selRef = pixFixedRef;
  case (styleSourceField)
    `PLS_STYLE_EXT_DIRECT: begin
      next_selFb  = pixelValueSlots[{2'b00, extSelSync}];
      next_selRef = pixFixedRef;
    end
    `PLS_STYLE_EXT_PAIR: begin
      // Multiply sits in the even slot, divide in the odd one
      next_selFb  = pixelValueSlots[{1'b0, extSelSync, 1'b0}];
      next_selRef = pixelValueSlots[{1'b0, extSelSync, 1'b1}][4:0];
    end
    `PLS_STYLE_INT_DIRECT: begin
      next_selFb  = pixelValueSlots[internalFreqSelectField];
      next_selRef = pixFixedRef;
    end
    `PLS_STYLE_INT_PAIR: begin
      // Top select bit has no meaning with only eight pairs
      next_selFb  = pixelValueSlots[{internalFreqSelectField[2:0], 1'b0}];
      next_selRef = pixelValueSlots[{internalFreqSelectField[2:0], 1'b1}][4:0];
    end
    default: begin
      // Codes outside the legacy set fall back to external direct
      next_selFb  = pixelValueSlots[{2'b00, extSelSync}];
      next_selRef = pixFixedRef;
    end
  endcase
end

// ------------------------------------------------------------
// PLL programming outputs
// ------------------------------------------------------------
always @(posedge clock or posedge sys_rst) begin
  if (sys_rst) begin
    sysRefCount        <= `PLS_RST_SYS_REF;
    sysFeedbackDivider <= 8'h00;
    sysRangeSelectCode <= 2'h0;
    sysPreDivideTwo    <= 1'b0;
    sysPostDivide      <= 3'h0;
    sysTotalRefDivide  <= 8'h00;
    pixRefCount        <= `PLS_RST_PIX_FIXED;
    pixFeedbackDivider <= 8'h00;
    pixRangeSelectCode <= 2'h0;
    pixPreDivideTwo    <= 1'b0;
    pixPostDivide      <= 3'h0;
    pixTotalRefDivide  <= 8'h00;
  end else begin
    // Whole pair updates in one edge so no mixed pair is seen
    sysRefCount        <= sysRefReg;
    sysFeedbackDivider <= feedbackDivider(sysFbReg[5:0]);
    sysRangeSelectCode <= sysFbReg[7:6];
    sysPreDivideTwo    <= preDivideTwo(sysFbReg[7:6]);
    sysPostDivide      <= postDivide(sysFbReg[7:6]);
    sysTotalRefDivide  <= totalRefDivide(sysRefReg, sysFbReg[7:6]);
    pixRefCount        <= next_selRef;
    pixFeedbackDivider <= feedbackDivider(next_selFb[5:0]);
    pixRangeSelectCode <= next_selFb[7:6];
    pixPreDivideTwo    <= preDivideTwo(next_selFb[7:6]);
    pixPostDivide      <= postDivide(next_selFb[7:6]);
    pixTotalRefDivide  <= totalRefDivide(next_selRef, next_selFb[7:6]);
  end
end

// ------------------------------------------------------------
// Read decode
// ------------------------------------------------------------
always @* begin
  rdIndex = regIndex(araddr);
  rdValue = 8'h00;
  rdHit   = 1'b1;
  if (rdIndex == {1'b0, `PLS_IDX_PIX_CTRL1}) begin
    rdValue = {5'b00000, styleSourceField};
  end else if (rdIndex == {1'b0, `PLS_IDX_PIX_CTRL2}) begin
    rdValue = {4'h0, internalFreqSelectField};
  end else if (rdIndex == {1'b0, `PLS_IDX_PIX_FIXED}) begin
    rdValue = {3'b000, pixFixedRef};
  end else if (rdIndex == {1'b0, `PLS_IDX_SYS_REF}) begin
    rdValue = {3'b000, sysRefReg};
  end else if (rdIndex == {1'b0, `PLS_IDX_SYS_FB}) begin
    rdValue = sysFbReg;
  end else if (rdIndex >= {1'b0, `PLS_IDX_SLOT_BASE} &&
               rdIndex <= {1'b0, `PLS_IDX_SLOT_LAST}) begin
    rdValue = pixelValueSlots[rdIndex[3:0]];
  end else if (rdIndex == {1'b0, `PLS_IDX_RB_FB}) begin
    rdValue = {pixRangeSelectCode, pixFeedbackDivider[5:0] - 6'h01};
  end else if (rdIndex == {1'b0, `PLS_IDX_RB_REF}) begin
    rdValue = {3'b000, pixRefCount};
  end else begin
    rdHit = 1'b0;
  end
end

// ------------------------------------------------------------
// AXI4-Lite slave and register writes
// ------------------------------------------------------------
always @* begin
  wrIndex = regIndex(awAddrHeld);
end

always @(posedge clock or posedge sys_rst) begin
  if (sys_rst) begin
    awready                 <= 1'b1;
    wready                  <= 1'b1;
    bvalid                  <= 1'b0;
    bresp                   <= `PLS_RESP_OKAY;
    arready                 <= 1'b1;
    rvalid                  <= 1'b0;
    rresp                   <= `PLS_RESP_OKAY;
    rdata                   <= 32'h00000000;
    awHeld                  <= 1'b0;
    wHeld                   <= 1'b0;
    awAddrHeld              <= {ADDR_WIDTH{1'b0}};
    wByteHeld               <= 8'h00;
    wLaneHeld               <= 1'b0;
    sysRefReg               <= `PLS_RST_SYS_REF;
    sysFbReg                <= `PLS_RST_SYS_FB;
    pixFixedRef             <= `PLS_RST_PIX_FIXED;
    styleSourceField        <= `PLS_RST_STYLE;
    internalFreqSelectField <= `PLS_RST_INT_SEL;
    for (i = 0; i < 16; i = i + 1) begin
      pixelValueSlots[i] <= `PLS_RST_SLOT_OTHER;
    end
    pixelValueSlots[0]      <= `PLS_RST_SLOT0;
    pixelValueSlots[1]      <= `PLS_RST_SLOT1;
  end else begin
    if (awvalid && awready) begin
      awAddrHeld <= awaddr;
      awHeld     <= 1'b1;
      awready    <= 1'b0;
    end
    if (wvalid && wready) begin
      wByteHeld <= wdata[7:0];
      wLaneHeld <= wstrb[0];
      wHeld     <= 1'b1;
      wready    <= 1'b0;
    end
    if (awHeld && wHeld && !bvalid) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      bvalid <= 1'b1;
      bresp  <= `PLS_RESP_OKAY;
      // Only lane 0 carries data; other lanes are ignored
      if (wrIndex == {1'b0, `PLS_IDX_PIX_CTRL1}) begin
        if (wLaneHeld) begin
          styleSourceField <= wByteHeld[2:0];
        end
      end else if (wrIndex == {1'b0, `PLS_IDX_PIX_CTRL2}) begin
        if (wLaneHeld) begin
          internalFreqSelectField <= wByteHeld[3:0];
        end
      end else if (wrIndex == {1'b0, `PLS_IDX_PIX_FIXED}) begin
        if (wLaneHeld) begin
          pixFixedRef <= wByteHeld[4:0];
        end
      end else if (wrIndex == {1'b0, `PLS_IDX_SYS_REF}) begin
        if (wLaneHeld) begin
          sysRefReg <= wByteHeld[4:0];
        end
      end else if (wrIndex == {1'b0, `PLS_IDX_SYS_FB}) begin
        if (wLaneHeld) begin
          sysFbReg <= wByteHeld;
        end
      end else if (wrIndex >= {1'b0, `PLS_IDX_SLOT_BASE} &&
                   wrIndex <= {1'b0, `PLS_IDX_SLOT_LAST}) begin
        if (wLaneHeld) begin
          pixelValueSlots[wrIndex[3:0]] <= wByteHeld;
        end
      end else if (wrIndex == {1'b0, `PLS_IDX_RB_FB} ||
                   wrIndex == {1'b0, `PLS_IDX_RB_REF}) begin
        // Readback registers ignore writes
        bresp <= `PLS_RESP_OKAY;
      end else begin
        bresp <= `PLS_RESP_SLVERR;
      end
    end
    if (bvalid && bready) begin
      bvalid  <= 1'b0;
      awready <= 1'b1;
      wready  <= 1'b1;
    end
    if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= {24'h000000, rdValue};
      rresp   <= rdHit ? `PLS_RESP_OKAY : `PLS_RESP_SLVERR;
    end
    if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end
end

endmodule // pls_pll_select
